// ===== src/usb_core_defs.vh
// Purpose: Constants for the USB device control, event flag and bus status block
// Assumes: Avalon-MM word bus, byte addresses, 25 MHz clock
// Notes: How it works list follows
`ifndef USB_CORE_DEFS_VH
`define USB_CORE_DEFS_VH
`define OFS_CONTROL    8'h40
`define OFS_FLAGS      8'h44
`define OFS_STATUS     8'h48
`define CTL_RESET      16'h0003
`define CTL_IRQ_EN_HI  15
`define CTL_IRQ_EN_LO  8
`define CTL_RESUME     4
`define CTL_SUSPEND    3
`define CTL_LOWPWR     2
`define CTL_CLOSE      1
`define CTL_SOFTRST    0
`define FLG_XFER       15
`define FLG_PKTMEM     14
`define FLG_ERROR      13
`define FLG_WAKE       12
`define FLG_SUSP       11
`define FLG_BUSRST     10
`define FLG_SOF        9
`define FLG_ESOF       8
`define FLG_DIR        4
`define IDLE_TIME_US   3000
`define CLK_MHZ        25
`define IDLE_CYCLES    (`IDLE_TIME_US * `CLK_MHZ)
`endif

// ===== src/usb_device_core_ctrl_status.v
// Purpose: Control, event flag and bus status registers of a full-speed USB device core
// Assumes: Transaction and SOF events arrive as single-cycle pulses from the packet engine
// Notes: Reads and writes answer with one wait cycle; unmapped reads return zero

`include "usb_core_defs.vh"

module usb_device_core_ctrl_status #(
  parameter IDLE_CYCLES = `IDLE_CYCLES             // Bus idle time before suspend request
) (
  input  wire        clk_i,                        // 25 MHz clock
  input  wire        rstn_i,                       // Async reset, active low
  input  wire [7:0]  avs_address_i,                // Byte address
  input  wire        avs_read_i,                   // Read request
  input  wire        avs_write_i,                  // Write request
  input  wire [31:0] avs_writedata_i,              // Write data
  input  wire [3:0]  avs_byteenable_i,             // Byte enables
  output reg  [31:0] avs_readdata_o,               // Read data
  output reg         avs_waitrequest_o,            // Wait request
  input  wire        dplus_i,                      // D+ receiver level (async)
  input  wire        dminus_i,                     // D- receiver level (async)
  input  wire        xfer_ok_i,                    // Transaction finished correctly
  input  wire        xfer_out_i,                   // Direction of that transaction, 1 = OUT
  input  wire [3:0]  xfer_ep_i,                    // Endpoint of that transaction
  input  wire        xfer_hp_i,                    // Endpoint is isochronous or double-buffered bulk
  input  wire        pktmem_fault_i,               // Packet memory overrun or underrun
  input  wire        xfer_error_i,                 // Transaction error
  input  wire        bus_activity_i,               // Any bus traffic seen this cycle
  input  wire        bus_reset_i,                  // Reset signalling detected
  input  wire        sof_i,                        // SOF packet received
  input  wire        sof_missed_i,                 // Expected SOF did not arrive
  output reg         irq_lo_o,                     // Low-priority interrupt
  output reg         irq_hi_o,                     // High-priority interrupt
  output reg         resume_o,                     // Resume request upstream
  output reg         suspend_o,                    // Device in suspend state
  output reg         low_power_o,                  // Transceiver in low-power mode
  output reg         disconnect_o,                 // Device closed and disconnected
  output reg         core_reset_o                  // Peripheral held in reset
);

  reg  [15:0] ctl_q;
  reg  [7:0]  flags_q;
  reg         dir_q;
  reg  [3:0]  ep_q;
  reg         hp_pend_q;
  reg  [1:0]  dp_sync_q;
  reg  [1:0]  dm_sync_q;
  reg         lock_q;
  reg         sof_seen_q;
  reg  [1:0]  lost_q;
  reg  [10:0] fnum_q;
  reg  [31:0] idle_cnt_q;
  reg         req_q;
  reg  [7:0]  set_d;

  wire        wr_go   = avs_write_i & req_q;
  wire        low_we  = avs_byteenable_i[0];
  wire        high_we = avs_byteenable_i[1];
  wire        susp_idle = (idle_cnt_q == IDLE_CYCLES - 1);

  // Merge byte enables into a 16-bit register image
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] wd;
    input        b0;
    input        b1;
    begin
      merge16 = {b1 ? wd[15:8] : old[15:8], b0 ? wd[7:0] : old[7:0]};
    end
  endfunction

  // Hardware event sources, one per flag bit 15..8
  always @* begin
    set_d = {xfer_ok_i,
             pktmem_fault_i,
             xfer_error_i,
             ctl_q[`CTL_SUSPEND] & bus_activity_i,
             susp_idle & ~ctl_q[`CTL_SUSPEND],
             bus_reset_i,
             sof_i,
             sof_missed_i & ~ctl_q[`CTL_SUSPEND]};
  end

  // Bus slave: one wait cycle, then the access completes
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      req_q             <= 1'b0;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h00000000;
    end else begin
      req_q             <= (avs_read_i | avs_write_i) & ~req_q;
      avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & ~req_q);
      if (avs_read_i & ~req_q) begin
        case (avs_address_i)
          `OFS_CONTROL: avs_readdata_o <= {16'h0000, ctl_q};
          `OFS_FLAGS:   avs_readdata_o <= {16'h0000, flags_q, 3'b000, dir_q, ep_q};
          `OFS_STATUS:  avs_readdata_o <= {16'h0000, dp_sync_q[1], dm_sync_q[1], lock_q, lost_q, fnum_q};
          default:      avs_readdata_o <= 32'h00000000;
        endcase
      end
    end
  end

  // Control register; low-power clears itself once the wake flag is set while suspend is on
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctl_q <= `CTL_RESET;
    end else if (wr_go && avs_address_i == `OFS_CONTROL) begin
      ctl_q <= merge16(ctl_q, avs_writedata_i, low_we, high_we) & 16'hFF1F;
    end else if (ctl_q[`CTL_SUSPEND] && flags_q[`FLG_WAKE - 8]) begin
      ctl_q[`CTL_LOWPWR] <= 1'b0;
    end
  end

  // Event flags: write zero clears, write one keeps, a new event wins over clear
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flags_q <= 8'h00;
      dir_q   <= 1'b0;
      ep_q    <= 4'h0;
    end else begin
      if (wr_go && avs_address_i == `OFS_FLAGS && high_we)
        flags_q <= (flags_q & avs_writedata_i[15:8]) | set_d;
      else
        flags_q <= flags_q | set_d;
      if (xfer_ok_i) begin
        dir_q <= xfer_out_i;
        ep_q  <= xfer_ep_i;
      end
    end
  end

  // High-priority pending follows the transfer flag but only for fast endpoints
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i)
      hp_pend_q <= 1'b0;
    else if (xfer_ok_i)
      hp_pend_q <= xfer_hp_i;
    else if (!flags_q[`FLG_XFER - 8])
      hp_pend_q <= 1'b0;
  end

  // Line levels come from pins, so two flops before use
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dp_sync_q <= 2'b00;
      dm_sync_q <= 2'b00;
    end else begin
      dp_sync_q <= {dp_sync_q[0], dplus_i};
      dm_sync_q <= {dm_sync_q[0], dminus_i};
    end
  end

  // Frame tracking; the status register has no write path at all
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lock_q     <= 1'b0;
      sof_seen_q <= 1'b0;
      lost_q     <= 2'b00;
      fnum_q     <= 11'h000;
    end else if (bus_reset_i) begin
      lock_q     <= 1'b0;
      sof_seen_q <= 1'b0;
      lost_q     <= 2'b00;
    end else if (sof_i) begin
      sof_seen_q <= 1'b1;
      lock_q     <= lock_q | sof_seen_q;
      lost_q     <= 2'b00;
      fnum_q     <= fnum_q + 11'h001;
    end else if (set_d[0]) begin
      // A missed frame breaks the run of consecutive SOFs, so lock must be earned again
      lock_q     <= 1'b0;
      sof_seen_q <= 1'b0;
      lost_q     <= lost_q + 2'b01;
    end
  end

  // Idle timer for the suspend request; saturates so the flag fires once per idle spell
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i)
      idle_cnt_q <= 32'h00000000;
    else if (bus_activity_i || ctl_q[`CTL_SOFTRST])
      idle_cnt_q <= 32'h00000000;
    else if (idle_cnt_q < IDLE_CYCLES)
      idle_cnt_q <= idle_cnt_q + 32'h00000001;
  end

  // Registered outputs
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_lo_o     <= 1'b0;
      irq_hi_o     <= 1'b0;
      resume_o     <= 1'b0;
      suspend_o    <= 1'b0;
      low_power_o  <= 1'b0;
      disconnect_o <= 1'b1;
      core_reset_o <= 1'b1;
    end else begin
      irq_lo_o     <= |(flags_q & ctl_q[`CTL_IRQ_EN_HI:`CTL_IRQ_EN_LO]);
      irq_hi_o     <= flags_q[`FLG_XFER - 8] & ctl_q[`CTL_IRQ_EN_HI] & hp_pend_q;
      resume_o     <= ctl_q[`CTL_RESUME];
      suspend_o    <= ctl_q[`CTL_SUSPEND];                                          // Software-set suspend state
      low_power_o  <= ctl_q[`CTL_LOWPWR] & ctl_q[`CTL_SUSPEND];
      disconnect_o <= ctl_q[`CTL_CLOSE];
      core_reset_o <= ctl_q[`CTL_SOFTRST];
    end
  end

endmodule // usb_device_core_ctrl_status

// ===== tb/tb.sv
// Purpose: Self-checking bench of the USB control block
// Assumes: Idle time cut to IDLE cycles
// Notes: An idle cycle between accesses avoids races
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int IDLE = 50;
  logic clk_i = 1'b0, rstn_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0, xfer_out_i = 1'b1, xfer_hp_i = 1'b1;
  logic avs_waitrequest_o, dplus_i, dminus_i, bus_activity_i, xfer_ok_i, pktmem_fault_i, xfer_error_i, bus_reset_i;
  logic sof_i, sof_missed_i, irq_lo_o, irq_hi_o, resume_o, suspend_o, low_power_o, disconnect_o, core_reset_o;
  logic [7:0] avs_address_i = 8'h00;
  logic [3:0] avs_byteenable_i = 4'h3, xfer_ep_i = 4'hA;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, q, e;
  logic [10:0] fn;
  int fail_count = 0, num_checks = 0, i;
  always #20 clk_i = ~clk_i;
  usb_device_core_ctrl_status #(.IDLE_CYCLES(IDLE)) u_usb_device_core_ctrl_status (.*);
  usb_host_model u_usb_host_model (.clk_i, .ev_o({xfer_ok_i, pktmem_fault_i, xfer_error_i, bus_reset_i, sof_i,
    sof_missed_i}), .act_o(bus_activity_i), .dp_o(dplus_i), .dm_o(dminus_i));
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x) begin
      fail_count++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, x);
    end
  endtask
  // Request held until waitrequest is seen low; bounded wait
  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_read_i <= !wr;
    avs_write_i <= wr;
    avs_address_i <= a;
    avs_writedata_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    if (n >= 50) begin
      chk(32'h0, 32'h1);
      close_out();
    end
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    acc(1'b0, a, 32'h0);
    chk(q, x);
  endtask
  task automatic ev(input int k);
    u_usb_host_model.pulse(k);
  endtask
  // Each event sets its flag; ones keep it, zeros clear it
  task automatic t_events();
    acc(1'b1, 8'h40, 32'hFF00);
    acc(1'b1, 8'h44, 32'h0);
    for (i = 5; i >= 0; i--) begin
      e = (32'h1 << (i > 2 ? 10 + i : 8 + i)) | 32'h1A;
      ev(i);
      rdc(8'h44, e);
      chk(32'({irq_lo_o, irq_hi_o}), {30'h0, 1'b1, i == 5});
      acc(1'b1, 8'h44, 32'hFFFF);
      rdc(8'h44, e);
      acc(1'b1, 8'h44, 32'h0);
    end
    xfer_out_i <= 1'b0;
    xfer_ep_i <= 4'h5;
    xfer_hp_i <= 1'b0;
    ev(5);
    rdc(8'h44, 32'h8005);
    chk(32'({irq_lo_o, irq_hi_o}), 32'h2);
    acc(1'b1, 8'h40, 32'h0);
    ev(3);
    rdc(8'h44, 32'hA005);
    chk(32'(irq_lo_o), 32'h0);
    $display("t_events done");
  endtask
  // SOF, missed SOF and read-only status
  task automatic t_frames();
    ev(2);
    acc(1'b0, 8'h48, 32'h0);
    fn = q[10:0];
    ev(1);
    ev(1);
    rdc(8'h48, {16'h0, 5'b10100, fn + 11'd2});
    ev(0);
    ev(0);
    acc(1'b1, 8'h48, 32'h0);
    rdc(8'h48, {16'h0, 5'b10010, fn + 11'd2});
    ev(1);
    rdc(8'h48, {16'h0, 5'b10000, fn + 11'd3});
    $display("t_frames done");
  endtask
  // Idle bus, suspend, then wake by activity
  task automatic t_suspend();
    u_usb_host_model.act_o <= 1'b0;
    acc(1'b1, 8'h44, 32'h0);
    repeat (IDLE - 10) @(posedge clk_i);
    rdc(8'h44, 32'h0005);
    repeat (20) @(posedge clk_i);
    rdc(8'h44, 32'h0805);
    acc(1'b1, 8'h40, 32'h000C);
    rdc(8'h40, 32'h000C);
    chk(32'({suspend_o, low_power_o}), 32'h3);
    u_usb_host_model.act_o <= 1'b1;
    rdc(8'h44, 32'h1805);
    rdc(8'h40, 32'h0008);
    $display("t_suspend done");
  endtask
  // Reset values, resume, unmapped place, close again
  initial begin
    repeat (10) @(posedge clk_i);
    rstn_i <= 1'b1;
    rdc(8'h40, 32'h3);
    chk(32'({disconnect_o, core_reset_o}), 32'h3);
    t_events();
    t_frames();
    t_suspend();
    acc(1'b1, 8'h40, 32'h0010);
    rdc(8'h4C, 32'h0);
    chk(32'(resume_o), 32'h1);
    acc(1'b1, 8'h40, 32'h0003);
    rdc(8'h40, 32'h0003);
    $display("t_misc done");
    close_out();
  end
endmodule // tb

// ===== tb/usb_ctrl_properties.sv
// Purpose: Port properties of the USB control block
// Assumes: Control writes reach pins within two edges
// Notes: Line levels judged only once settled
module usb_ctrl_checker (
  input wire logic        clk_i, rstn_i, avs_read_i, avs_write_i, avs_waitrequest_o, // Clock, reset, bus
  input wire logic [7:0]  avs_address_i,    // Byte address
  input wire logic [3:0]  avs_byteenable_i, // Byte enables
  input wire logic [31:0] avs_writedata_i, avs_readdata_o, // Bus data
  input wire logic        dplus_i, dminus_i, irq_lo_o, irq_hi_o, resume_o, disconnect_o, core_reset_o // Pins
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // Accepted control write and status read
  wire w = avs_write_i && !avs_waitrequest_o && avs_address_i == 8'h40 && avs_byteenable_i[0];
  wire r = avs_read_i && !avs_waitrequest_o && avs_address_i == 8'h48;
  property p_rst; $rose(rstn_i) |-> disconnect_o && core_reset_o; endproperty
  a_rst: assert property (p_rst) else $error("not closed");
  property p_quiet; $rose(rstn_i) |-> !irq_lo_o [*3]; endproperty
  a_quiet: assert property (p_quiet) else $error("early irq");
  property p_hi; irq_hi_o |-> irq_lo_o; endproperty
  a_hi: assert property (p_hi) else $error("lone high irq");
  property p_close; w && avs_writedata_i[1] |-> ##[1:2] disconnect_o; endproperty
  a_close: assert property (p_close) else $error("no close");
  property p_open; w && !avs_writedata_i[1] |-> ##[1:2] !disconnect_o; endproperty
  a_open: assert property (p_open) else $error("no open");
  property p_srst; w && !avs_writedata_i[0] |-> ##[1:2] !core_reset_o; endproperty
  a_srst: assert property (p_srst) else $error("reset held");
  property p_res; w && avs_writedata_i[4] |-> ##[1:2] resume_o; endproperty
  a_res: assert property (p_res) else $error("no resume");
  property p_line; $stable({dplus_i, dminus_i}) [*6] ##0 r |-> avs_readdata_o[15:14] == {dplus_i, dminus_i}; endproperty
  a_line: assert property (p_line) else $error("bad levels");
endmodule // usb_ctrl_checker
bind usb_device_core_ctrl_status usb_ctrl_checker u_chk (.*);

// ===== tb/usb_host_model.sv
// Purpose: Upstream host driving bus events
// Assumes: Idle bus is J, D+ high
// Notes: Events are one-cycle pulses
module usb_host_model (
  input  wire logic clk_i, // Clock
  output logic [5:0] ev_o, // ok,pkt,err,busrst,sof,miss
  output logic act_o,      // Activity level
  output logic dp_o,       // D+
  output logic dm_o        // D-
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle line, nothing pending
  initial begin
    ev_o = 6'h00;
    act_o = 1'b1;
    dp_o = 1'b1;
    dm_o = 1'b0;
  end
  // Full cycle so no event slips by
  task pulse(input int k);
    @(posedge clk_i);
    ev_o[k] <= 1'b1;
    @(posedge clk_i);
    ev_o[k] <= 1'b0;
  endtask
endmodule // usb_host_model
